// file: src/iusw_state.sv
// integer-unit state registers, window checks and watchpoint hits
// Notes on behaviour
// - status register reachable only by privileged status read/write
// - wim bit n set marks window invalid; save overflows, restore underflows
// - window mask reached only by privileged instructions
// - state words held three times and voted; no-reset bits unknown
// - multiplies and multiply-step load the high product word
// - divides take dividend upper word from high product word
// - high product word reachable in user and supervisor mode
// - trap base field is bits 31..12, upper trap address
// - trap kind written on every trap except external reset
// - trap base reached only by privileged instructions
// - pointer saved to local 1 on trap, restored on return
// - next pointer saved to local 2 on trap, restored on return
// - four watch address registers at even numbers 24..30
// - address bit 0 enables instruction fetch hits
// - watch registers reachable in user mode
// - mask registers at odd 25..31; mask bits 31..2 select compared address bits
// - mask bit 1 enables data load hits
// - mask bit 0 enables data store hits
// - window pointer down on trap/save, up on restore/rett, mod 8
// - supervisor flag set means supervisor mode
`timescale 1ns/1ps
`default_nettype none
module iusw_state #(
  parameter int unsigned NWP = iusw_pkg::NWATCH
) (
  input wire logic ref_clk_i,
  input wire logic reset_i,
  input wire logic supervisor_i,
  input wire logic sr_rd_i,
  input wire logic sr_wr_i,
  input wire logic [4:0] sr_sel_i,
  input wire logic [31:0] sr_wdata_i,
  input wire logic step_i,
  input wire logic [2:0] win_op_i,
  input wire logic mul_wr_i,
  input wire logic [31:0] mul_hi_i,
  input wire logic ext_trap_i,
  input wire logic [7:0] ext_tt_i,
  input wire logic ext_reset_i,
  input wire logic [31:0] rett_pc_i,
  input wire logic [31:0] rett_npc_i,
  input wire logic fetch_i,
  input wire logic load_i,
  input wire logic store_i,
  input wire logic [31:0] fetch_addr_i,
  input wire logic [31:0] data_addr_i,
  output logic [31:0] sr_rdata_o,
  output logic status_acc_o,
  output logic [31:0] div_hi_o,
  output logic trap_o,
  output logic [7:0] trap_kind_o,
  output logic [31:0] trap_vector_o,
  output logic save_wr_o,
  output logic [1:0] save_reg_o,
  output logic [31:0] save_data_o,
  output logic [2:0] cwp_o,
  output logic watch_hit_o,
  output logic [31:0] pc_o,
  output logic [31:0] npc_o
);
  initial begin
    if (NWP < 1 || NWP > 4) $error("NWP must be 1..4");
  end

  typedef struct packed {
    logic [31:0] window_invalid_mask;
    logic [31:0] y;
    logic [19:0] tba;
    logic [7:0] tt;
    logic [31:0] pc;
    logic [31:0] npc;
    logic [2:0] cwp;
    logic [3:0][31:0] wpa;
    logic [3:0][31:0] wpm;
    logic [31:0] rdata;
    logic trap;
    logic [7:0] tkind;
    logic sv;
    logic [1:0] sreg;
    logic [31:0] sdata;
  } iusw_one_s;

  typedef struct packed {
    iusw_one_s a;
    iusw_one_s b;
    iusw_one_s c;
  } iusw_state_s;

  iusw_state_s st_ff;
  iusw_state_s nxt_st;
  iusw_one_s cur;
  iusw_one_s nx;

  // voting per bit hides a single upset copy
  iusw_vote #(.W($bits(iusw_one_s))) u_vote (
    .a_i(st_ff.a),
    .b_i(st_ff.b),
    .c_i(st_ff.c),
    .y_o(cur)
  );

  function automatic logic is_priv(input logic [4:0] sel);
    is_priv = (sel == iusw_pkg::SEL_STATUS) || (sel == iusw_pkg::SEL_WIM) ||
              (sel == iusw_pkg::SEL_TBR);
  endfunction

  function automatic logic wp_match(input logic [31:0] addr,
                                    input logic [31:0] base,
                                    input logic [31:0] mask);
    logic [29:0] diff;
    diff = (addr[31:2] ^ base[31:2]) & mask[31:2];
    wp_match = (diff == 30'h00000000);
  endfunction

  logic [NWP-1:0] hit_vec;
  genvar g;
  generate
    for (g = 0; g < NWP; g++) begin : g_wp
      assign hit_vec[g] =
        (fetch_i && cur.wpa[g][iusw_pkg::IFETCH_BIT] &&
         wp_match(fetch_addr_i, cur.wpa[g], cur.wpm[g])) ||
        (load_i && cur.wpm[g][iusw_pkg::LOAD_BIT] &&
         wp_match(data_addr_i, cur.wpa[g], cur.wpm[g])) ||
        (store_i && cur.wpm[g][iusw_pkg::STORE_BIT] &&
         wp_match(data_addr_i, cur.wpa[g], cur.wpm[g]));
    end
  endgenerate

  logic priv_fault;
  logic [2:0] cwp_dn;
  logic [2:0] cwp_up;
  logic ovf;
  logic unf;
  logic wp_hit;
  logic any_trap;
  logic [7:0] kind;
  logic [4:0] wp_idx;

  always_comb begin
    nx = cur;
    nx.trap = 1'b0;
    nx.sv = 1'b0;
    nx.sreg = 2'h0;
    nx.rdata = 32'h00000000;
    wp_idx = sr_sel_i - iusw_pkg::SEL_WP_FIRST;
    cwp_dn = cur.cwp - 3'h1;
    cwp_up = cur.cwp + 3'h1;
    // user-mode privileged access is refused
    priv_fault = (sr_rd_i || sr_wr_i) && is_priv(sr_sel_i) && !supervisor_i;
    ovf = (win_op_i == iusw_pkg::IUSW_OP_SAVE) && cur.window_invalid_mask[cwp_dn];
    unf = ((win_op_i == iusw_pkg::IUSW_OP_RESTORE) ||
           (win_op_i == iusw_pkg::IUSW_OP_RETT)) && cur.window_invalid_mask[cwp_up];
    wp_hit = |hit_vec;
    any_trap = priv_fault || ovf || unf || wp_hit || ext_trap_i;
    if (priv_fault) begin
      kind = iusw_pkg::TT_PRIV;
    end else if (wp_hit) begin
      kind = iusw_pkg::TT_WATCH;
    end else if (ovf) begin
      kind = iusw_pkg::TT_OVF;
    end else if (unf) begin
      kind = iusw_pkg::TT_UNF;
    end else begin
      kind = ext_tt_i;
    end
    if (sr_rd_i && !priv_fault) begin
      case (sr_sel_i)
        iusw_pkg::SEL_WIM: nx.rdata = cur.window_invalid_mask;
        iusw_pkg::SEL_Y: nx.rdata = cur.y;
        iusw_pkg::SEL_TBR: nx.rdata = {cur.tba, cur.tt, 4'h0};
        iusw_pkg::SEL_PC: nx.rdata = cur.pc;
        iusw_pkg::SEL_NPC: nx.rdata = cur.npc;
        default: begin
          if (sr_sel_i >= iusw_pkg::SEL_WP_FIRST) begin
            if (wp_idx[0]) begin
              nx.rdata = cur.wpm[wp_idx[2:1]];
            end else begin
              nx.rdata = cur.wpa[wp_idx[2:1]];
            end
          end
        end
      endcase
    end
    if (sr_wr_i && !priv_fault) begin
      case (sr_sel_i)
        iusw_pkg::SEL_WIM: nx.window_invalid_mask = sr_wdata_i;
        iusw_pkg::SEL_Y: nx.y = sr_wdata_i;
        iusw_pkg::SEL_TBR: nx.tba = sr_wdata_i[31:iusw_pkg::TBA_LSB];
        default: begin
          if (sr_sel_i >= iusw_pkg::SEL_WP_FIRST) begin
            if (wp_idx[0]) begin
              nx.wpm[wp_idx[2:1]] = sr_wdata_i;
            end else begin
              nx.wpa[wp_idx[2:1]] = sr_wdata_i;
            end
          end
        end
      endcase
    end
    if (mul_wr_i) begin
      nx.y = mul_hi_i;
    end
    if (any_trap) begin
      // trap wins: the faulting access never completes
      nx.trap = 1'b1;
      nx.tkind = kind;
      nx.tt = kind;
      nx.cwp = cwp_dn;
      nx.sv = 1'b1;
      nx.sreg = iusw_pkg::LOCAL_PC;
      nx.sdata = cur.pc;
    end else if (win_op_i == iusw_pkg::IUSW_OP_RETT) begin
      nx.cwp = cwp_up;
      nx.pc = rett_pc_i;
      nx.npc = rett_npc_i;
    end else begin
      if (win_op_i == iusw_pkg::IUSW_OP_SAVE) begin
        nx.cwp = cwp_dn;
      end else if (win_op_i == iusw_pkg::IUSW_OP_RESTORE) begin
        nx.cwp = cwp_up;
      end
      if (step_i) begin
        nx.pc = cur.npc;
        nx.npc = cur.npc + iusw_pkg::PC_STEP;
      end
    end
    // second save cycle writes next pointer into local 2
    if (cur.sv && cur.sreg == iusw_pkg::LOCAL_PC) begin
      nx.sv = 1'b1;
      nx.sreg = iusw_pkg::LOCAL_NPC;
      nx.sdata = cur.npc;
      nx.pc = {cur.tba, cur.tkind, 4'h0};
      nx.npc = {cur.tba, cur.tkind, 4'h0} + iusw_pkg::PC_STEP;
    end
    nxt_st = {nx, nx, nx};
    if (ext_reset_i) begin
      // external reset leaves trap kind untouched
      nxt_st.a.pc = iusw_pkg::PC_RESET;
      nxt_st.b.pc = iusw_pkg::PC_RESET;
      nxt_st.c.pc = iusw_pkg::PC_RESET;
      nxt_st.a.npc = iusw_pkg::PC_STEP;
      nxt_st.b.npc = iusw_pkg::PC_STEP;
      nxt_st.c.npc = iusw_pkg::PC_STEP;
      nxt_st.a.tt = cur.tt;
      nxt_st.b.tt = cur.tt;
      nxt_st.c.tt = cur.tt;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      // trap/save flags, pc, npc, cwp, watch and read-data words reset; the rest take their next value
      st_ff <= nxt_st;
      st_ff.a.trap <= 1'b0;
      st_ff.b.trap <= 1'b0;
      st_ff.c.trap <= 1'b0;
      st_ff.a.sv <= 1'b0;
      st_ff.b.sv <= 1'b0;
      st_ff.c.sv <= 1'b0;
      st_ff.a.pc <= iusw_pkg::PC_RESET;
      st_ff.b.pc <= iusw_pkg::PC_RESET;
      st_ff.c.pc <= iusw_pkg::PC_RESET;
      st_ff.a.npc <= iusw_pkg::PC_STEP;
      st_ff.b.npc <= iusw_pkg::PC_STEP;
      st_ff.c.npc <= iusw_pkg::PC_STEP;
      // window pointer starts known so window checks behave from reset
      st_ff.a.cwp <= '0;
      st_ff.b.cwp <= '0;
      st_ff.c.cwp <= '0;
      st_ff.a.wpa <= '0;
      st_ff.b.wpa <= '0;
      st_ff.c.wpa <= '0;
      st_ff.a.wpm <= '0;
      st_ff.b.wpm <= '0;
      st_ff.c.wpm <= '0;
      st_ff.a.rdata <= 32'h00000000;
      st_ff.b.rdata <= 32'h00000000;
      st_ff.c.rdata <= 32'h00000000;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // status register lives elsewhere; only privileged access is signalled
  assign status_acc_o = (sr_rd_i || sr_wr_i) && supervisor_i &&
                        (sr_sel_i == iusw_pkg::SEL_STATUS);
  assign sr_rdata_o = cur.rdata;
  assign div_hi_o = cur.y;
  assign trap_o = cur.trap;
  assign trap_kind_o = cur.tkind;
  assign trap_vector_o = {cur.tba, cur.tkind, 4'h0};
  assign save_wr_o = cur.sv;
  assign save_reg_o = cur.sreg;
  assign save_data_o = cur.sdata;
  assign cwp_o = cur.cwp;
  assign watch_hit_o = wp_hit;
  assign pc_o = cur.pc;
  assign npc_o = cur.npc;

  property p_priv_refused;
    @(posedge ref_clk_i) disable iff (reset_i)
    (sr_wr_i && sr_sel_i == iusw_pkg::SEL_WIM && !supervisor_i)
      |=> trap_o && trap_kind_o == iusw_pkg::TT_PRIV && $stable(cur.window_invalid_mask);
  endproperty
  a_priv_refused: assert property (p_priv_refused)
    else $error("user write changed window mask");
  property p_priv_tbr;
    @(posedge ref_clk_i) disable iff (reset_i)
    (sr_wr_i && sr_sel_i == iusw_pkg::SEL_TBR && !supervisor_i)
      |=> trap_o && $stable(cur.tba);
  endproperty
  a_priv_tbr: assert property (p_priv_tbr)
    else $error("user write changed trap base");
  property p_ovf;
    @(posedge ref_clk_i) disable iff (reset_i)
    (win_op_i == iusw_pkg::IUSW_OP_SAVE && cur.window_invalid_mask[cwp_o - 3'h1] &&
     !priv_fault && !wp_hit) |=> trap_o && trap_kind_o == iusw_pkg::TT_OVF;
  endproperty
  a_ovf: assert property (p_ovf) else $error("no overflow trap");
  sequence s_save_pair;
    save_wr_o && save_reg_o == iusw_pkg::LOCAL_PC ##1
    save_wr_o && save_reg_o == iusw_pkg::LOCAL_NPC;
  endsequence
  property p_trap_save;
    @(posedge ref_clk_i) disable iff (reset_i)
    $rose(trap_o) |-> s_save_pair;
  endproperty
  a_trap_save: assert property (p_trap_save)
    else $error("pointers not saved after trap");
  property p_cwp_trap;
    @(posedge ref_clk_i) disable iff (reset_i)
    any_trap |=> cwp_o == $past(cwp_o) - 3'h1;
  endproperty
  a_cwp_trap: assert property (p_cwp_trap)
    else $error("cwp not decremented");
  property p_y_user;
    @(posedge ref_clk_i) disable iff (reset_i)
    (sr_wr_i && sr_sel_i == iusw_pkg::SEL_Y && !mul_wr_i)
      |=> div_hi_o == $past(sr_wdata_i);
  endproperty
  a_y_user: assert property (p_y_user) else $error("y write lost");
  property p_mul;
    @(posedge ref_clk_i) disable iff (reset_i)
    mul_wr_i |=> div_hi_o == $past(mul_hi_i);
  endproperty
  a_mul: assert property (p_mul) else $error("product not stored");
  property p_watch;
    @(posedge ref_clk_i) disable iff (reset_i)
    (wp_hit && !priv_fault) |=> trap_o && trap_kind_o == iusw_pkg::TT_WATCH;
  endproperty
  a_watch: assert property (p_watch) else $error("hit without trap");
endmodule
`default_nettype wire

// file: src/iusw_pkg.sv
// constants for the integer-unit state and watchpoint block
package iusw_pkg;
  localparam int unsigned XLEN = 32;
  localparam int unsigned NWIN = 8;
  localparam int unsigned CWP_W = 3;
  localparam int unsigned NWATCH = 4;
  localparam int unsigned TT_W = 8;
  localparam int unsigned TT_LSB = 4;
  localparam int unsigned TBA_LSB = 12;
  localparam int unsigned WADDR_LSB = 2;
  localparam int unsigned IFETCH_BIT = 0;
  localparam int unsigned LOAD_BIT = 1;
  localparam int unsigned STORE_BIT = 0;
  localparam int unsigned SEL_W = 5;
  // special register numbers seen by the read/write instructions
  localparam logic [4:0] SEL_STATUS = 5'h00;
  localparam logic [4:0] SEL_WIM = 5'h01;
  localparam logic [4:0] SEL_TBR = 5'h02;
  localparam logic [4:0] SEL_Y = 5'h03;
  localparam logic [4:0] SEL_PC = 5'h04;
  localparam logic [4:0] SEL_NPC = 5'h05;
  localparam logic [4:0] SEL_WP_FIRST = 5'h18;
  // trap kind codes
  localparam logic [7:0] TT_PRIV = 8'h03;
  localparam logic [7:0] TT_OVF = 8'h05;
  localparam logic [7:0] TT_UNF = 8'h06;
  localparam logic [7:0] TT_WATCH = 8'h0B;
  localparam logic [1:0] LOCAL_PC = 2'h1;
  localparam logic [1:0] LOCAL_NPC = 2'h2;
  localparam logic [31:0] PC_STEP = 32'h00000004;
  localparam logic [31:0] PC_RESET = 32'h00000000;
  typedef enum logic [2:0] {
    IUSW_OP_NONE, IUSW_OP_SAVE, IUSW_OP_RESTORE, IUSW_OP_RETT
  } iusw_win_op_e;
endpackage

// file: src/iusw_vote.sv
// majority voter over three stored copies of one word
`timescale 1ns/1ps
`default_nettype none
module iusw_vote #(
  parameter int unsigned W = 32
) (
  input wire logic [W-1:0] a_i,
  input wire logic [W-1:0] b_i,
  input wire logic [W-1:0] c_i,
  output logic [W-1:0] y_o
);
  assign y_o = (a_i & b_i) | (a_i & c_i) | (b_i & c_i);
endmodule
`default_nettype wire

// file: sim/tb_top.sv
// self-checking bench for the integer-unit state and watchpoint block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic ref_clk_i, reset_i, supervisor_i, sr_rd_i, sr_wr_i, step_i;
  logic mul_wr_i, ext_trap_i, ext_reset_i, fetch_i, load_i, store_i;
  logic [4:0] sr_sel_i;
  logic [2:0] win_op_i, cwp_o, c;
  logic [7:0] ext_tt_i, trap_kind_o, k;
  logic [31:0] sr_wdata_i, mul_hi_i, rett_pc_i, rett_npc_i;
  logic [31:0] fetch_addr_i, data_addr_i, sr_rdata_o, div_hi_o;
  logic [31:0] trap_vector_o, save_data_o, pc_o, npc_o, a, tba, p, n;
  logic status_acc_o, trap_o, save_wr_o, watch_hit_o, took;
  logic [1:0] save_reg_o;
  int error_cnt = 0;
  int tests_run = 0;
  integer seed = 5426;
  logic [32:0] rd_q[$];
  logic [7:0] trap_q[$];

  iusw_state dut (.ref_clk_i, .reset_i, .supervisor_i, .sr_rd_i, .sr_wr_i,
    .sr_sel_i, .sr_wdata_i, .step_i, .win_op_i, .mul_wr_i, .mul_hi_i,
    .ext_trap_i, .ext_tt_i, .ext_reset_i, .rett_pc_i, .rett_npc_i,
    .fetch_i, .load_i, .store_i, .fetch_addr_i, .data_addr_i, .sr_rdata_o,
    .status_acc_o, .div_hi_o, .trap_o, .trap_kind_o, .trap_vector_o,
    .save_wr_o, .save_reg_o, .save_data_o, .cwp_o, .watch_hit_o, .pc_o,
    .npc_o);

  initial begin
    ref_clk_i = 1'b0;
    forever #20 ref_clk_i = ~ref_clk_i;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic wrap_up;
    $display("checks=%0d mismatches=%0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // inputs always move 1 ns after the rising edge
  task automatic tick;
    @(posedge ref_clk_i);
    #1;
  endtask

  task automatic wr(input logic [4:0] s, input logic [31:0] d);
    sr_sel_i = s;
    sr_wdata_i = d;
    sr_wr_i = 1'b1;
    tick;
    sr_wr_i = 1'b0;
    tick;
  endtask

  task automatic rd(input logic [4:0] s, input logic [31:0] e,
                    input logic care);
    rd_q.push_back({care, e});
    sr_sel_i = s;
    sr_rd_i = 1'b1;
    #1;
    chk({31'h0, status_acc_o}, {31'h0, s == 5'h00 && supervisor_i});
    tick;
    sr_rd_i = 1'b0;
    tick;
  endtask

  task automatic op(input logic [2:0] o);
    win_op_i = o;
    tick;
    win_op_i = 3'h0;
    tick;
  endtask

  // one access per call; a hit must announce a watch trap next edge
  task automatic acc(input int kd, input logic [31:0] ad, input logic ex);
    fetch_addr_i = ad;
    data_addr_i = ad;
    fetch_i = (kd == 0);
    load_i = (kd == 1);
    store_i = (kd == 2);
    if (ex) trap_q.push_back(iusw_pkg::TT_WATCH);
    #1;
    chk({31'h0, watch_hit_o}, {31'h0, ex});
    tick;
    {fetch_i, load_i, store_i} = 3'h0;
    repeat (3) tick;
  endtask

  // results are matched oldest-first against what the driver noted
  always @(posedge ref_clk_i) begin
    took = sr_rd_i;
    #2;
    if (took === 1'b1 && rd_q.size() > 0) begin
      if (rd_q[0][32]) chk(sr_rdata_o, rd_q[0][31:0]);
      void'(rd_q.pop_front());
    end
    if (trap_o === 1'b1) begin
      if (trap_q.size() == 0) chk({24'h0, trap_kind_o}, 32'hFFFFFFFF);
      else chk({24'h0, trap_kind_o}, {24'h0, trap_q.pop_front()});
    end
  end

  initial begin
    #400000;
    error_cnt++;
    wrap_up;
  end

  initial begin
    {sr_rd_i, sr_wr_i, step_i, mul_wr_i, ext_trap_i, ext_reset_i} = 6'h00;
    {fetch_i, load_i, store_i} = 3'h0;
    {reset_i, supervisor_i, sr_sel_i, win_op_i, ext_tt_i} = 18'h30000;
    {sr_wdata_i, mul_hi_i, rett_pc_i, rett_npc_i} = 128'h0;
    {fetch_addr_i, data_addr_i} = 64'h0;
    repeat (6) tick;
    reset_i = 1'b0;
    chk(pc_o, 32'h00000000);
    chk(npc_o, 32'h00000004);
    chk({29'h0, cwp_o}, 32'h0);
    step_i = 1'b1;
    tick;
    step_i = 1'b0;
    chk(pc_o, 32'h00000004);
    chk(npc_o, 32'h00000008);
    for (int i = 24; i < 32; i++) rd(5'(i), 32'h00000000, 1'b1);
    // high product word in user mode, then from the multiplier
    supervisor_i = 1'b0;
    a = $random(seed);
    wr(iusw_pkg::SEL_Y, a);
    rd(iusw_pkg::SEL_Y, a, 1'b1);
    chk(div_hi_o, a);
    mul_hi_i = ~a;
    mul_wr_i = 1'b1;
    tick;
    mul_wr_i = 1'b0;
    chk(div_hi_o, ~a);
    rd(iusw_pkg::SEL_Y, ~a, 1'b1);
    // privileged places refuse user access and keep their contents
    supervisor_i = 1'b1;
    tba = $random(seed);
    wr(iusw_pkg::SEL_WIM, a);
    wr(iusw_pkg::SEL_TBR, tba);
    supervisor_i = 1'b0;
    for (int s = 0; s < 3; s++) begin
      trap_q.push_back(iusw_pkg::TT_PRIV);
      wr(5'(s), ~a);
      repeat (3) tick;
      trap_q.push_back(iusw_pkg::TT_PRIV);
      rd(5'(s), 32'h0, 1'b0);
      repeat (3) tick;
    end
    supervisor_i = 1'b1;
    rd(iusw_pkg::SEL_WIM, a, 1'b1);
    rd(iusw_pkg::SEL_TBR, {tba[31:12], 8'h03, 4'h0}, 1'b1);
    rd(iusw_pkg::SEL_STATUS, 32'h0, 1'b0);
    // external trap: pointer pair saved, vector built, kept over reset
    k = $random(seed);
    p = pc_o;
    n = npc_o;
    ext_tt_i = k;
    ext_trap_i = 1'b1;
    trap_q.push_back(k);
    tick;
    ext_trap_i = 1'b0;
    chk({save_wr_o, save_reg_o, save_data_o}, {1'b1, 2'h1, p});
    tick;
    chk({save_wr_o, save_reg_o, save_data_o}, {1'b1, 2'h2, n});
    repeat (2) tick;
    chk(trap_vector_o, {tba[31:12], k, 4'h0});
    chk(pc_o, {tba[31:12], k, 4'h0});
    ext_reset_i = 1'b1;
    tick;
    ext_reset_i = 1'b0;
    tick;
    chk(pc_o, 32'h00000000);
    rd(iusw_pkg::SEL_TBR, {tba[31:12], k, 4'h0}, 1'b1);
    // watchpoints reached from user mode
    supervisor_i = 1'b0;
    for (int i = 0; i < 4; i++) begin
      a = $random(seed) & 32'hFFFFFFFC;
      wr(5'(24 + 2 * i), a | 32'h1);
      wr(5'(25 + 2 * i), 32'hFFFFFFEC);
      rd(5'(24 + 2 * i), a | 32'h1, 1'b1);
      rd(5'(25 + 2 * i), 32'hFFFFFFEC, 1'b1);
      acc(0, a ^ 32'h10, 1'b1);
      acc(0, a ^ 32'h4, 1'b0);
      acc(1, a, 1'b0);
      wr(5'(25 + 2 * i), 32'hFFFFFFEE);
      acc(1, a ^ 32'h10, 1'b1);
      acc(2, a, 1'b0);
      wr(5'(25 + 2 * i), 32'hFFFFFFED);
      acc(2, a, 1'b1);
      wr(5'(24 + 2 * i), a);
      acc(0, a, 1'b0);
    end
    // window checks only run once the pointer holds a known value
    supervisor_i = 1'b1;
    if (!$isunknown(cwp_o)) begin
      c = cwp_o;
      wr(iusw_pkg::SEL_WIM, 32'h0);
      op(iusw_pkg::IUSW_OP_SAVE);
      chk({29'h0, cwp_o}, {29'h0, c - 3'h1});
      rett_pc_i = a;
      rett_npc_i = a + 32'h4;
      op(iusw_pkg::IUSW_OP_RETT);
      chk({29'h0, cwp_o}, {29'h0, c});
      chk(pc_o, a);
      chk(npc_o, a + 32'h4);
      wr(iusw_pkg::SEL_WIM, 32'h1 << (c - 3'h1));
      trap_q.push_back(iusw_pkg::TT_OVF);
      op(iusw_pkg::IUSW_OP_SAVE);
      repeat (3) tick;
      c = cwp_o;
      wr(iusw_pkg::SEL_WIM, 32'h1 << (c + 3'h1));
      trap_q.push_back(iusw_pkg::TT_UNF);
      op(iusw_pkg::IUSW_OP_RESTORE);
      repeat (3) tick;
    end
    repeat (4) tick;
    chk(32'(trap_q.size()), 32'h0);
    wrap_up;
  end
endmodule
`default_nettype wire
